//--- hw/hcp_pkg.sv
// Contract
// - serial output shifts on edge chosen by select
// - acknowledge low when read data driven
// - acknowledge low once write data accepted
// - ready low during access, high when done
// - read data driven while read strobe low
// - direction low: bus sampled under data strobe
// - direction high: device drives bus under strobe
// - bus carries address then bidirectional data
// - chip select high: host interface ignored
// - serial input sampled on shift clock rise
// - address latched on latch or strobe fall
// - two select pins choose control method
package hcp_pkg;
    localparam logic [1:0] MODE_HW = 2'h0;
    localparam logic [1:0] MODE_SER = 2'h1;
    localparam logic [1:0] MODE_DS = 2'h2;
    localparam logic [1:0] MODE_SEP = 2'h3;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_LAST = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'h1;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_CS_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int LAST_WD_LSB = 8;
    localparam logic [3:0] SER_CMD_LAST = 4'h7;
    localparam logic [3:0] SER_DATA_LAST = 4'hF;
    // pin bundle after synchronisation
    typedef struct packed {
        logic cs_n;
        logic [1:0] mode;
        logic shift_clk;
        logic serial_in_pin;
        logic output_edge_select;
        logic addr_latch;
        logic addr_strobe_input;
        logic rd_n;
        logic wr_n;
        logic data_strobe_n;
        logic read_write;
        logic [7:0] ad;
    } hcp_pins_t;
    // chip select and all strobes inactive
    localparam hcp_pins_t PINS_IDLE = 20'h8_0E00;
    typedef enum logic [2:0] {
        ACC_IDLE = 3'h1,
        ACC_WAIT = 3'h2,
        ACC_DONE = 3'h4
    } hcp_acc_t;
endpackage

//--- hw/hcp_host_port.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
module hcp_host_port import hcp_pkg::*; #(
    parameter int AW = 4,
    parameter int ACC_CYC = 2
) (
    input wire logic sys_clk, // 10 MHz clock
    input wire logic rst, // sync reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic chip_sel_n, // host chip select
    input wire logic [1:0] if_mode, // control method select
    input wire logic shift_clk, // serial shift clock
    input wire logic serial_in_pin, // serial data in
    input wire logic output_edge_select, // serial out edge select
    input wire logic addr_latch, // address latch, sep mode
    input wire logic addr_strobe_input, // address strobe, ds mode
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    input wire logic data_strobe_n, // data strobe
    input wire logic read_write, // direction, 1 = read
    input wire logic [7:0] ad_in, // bus, input side
    output logic [7:0] ad_out, // bus, output side
    output logic ad_oe, // bus output enable
    output logic serial_out_pin, // serial data out
    output logic ack_n, // acknowledge, ds mode
    output logic ready_out // ready, sep mode
);
    localparam int DEPTH = 1 << AW;

    function automatic logic [AW-1:0] idx(input logic [7:0] a);
        return a[AW-1:0];
    endfunction

    hcp_pins_t raw;
    hcp_pins_t s1_ff, s2_ff, s3_ff, cln_ff, prv_ff, nxt_cln;
    logic [7:0] mem_ff [DEPTH];
    logic [7:0] addr_ff, sh_ff, osh_ff, ad_out_ff, last_wd_ff, rdat;
    logic [3:0] cnt_ff;
    logic [7:0] wcnt_ff;
    logic [15:0] wr_cnt_ff;
    logic ser_rd_ff, sout_ff, ad_oe_ff, ack_ff, ready_ff, ctrl_en_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, rd_word;
    hcp_acc_t acc_ff;
    logic active, ser, sep, dsm, sclk_rise, sclk_fall, act_edge;
    logic rd_act, wr_act, wr_rise, ds_act, ds_wr, strb;
    logic wr_en;
    logic [AW-1:0] wr_idx;
    logic [7:0] wr_dat;

    assign raw = {chip_sel_n, if_mode, shift_clk, serial_in_pin, output_edge_select, addr_latch,
                  addr_strobe_input, rd_n, wr_n, data_strobe_n, read_write, ad_in};

    // a bit moves only when the second and third stages agree
    always_comb begin
        nxt_cln = (s2_ff & ~(s2_ff ^ s3_ff)) | (cln_ff & (s2_ff ^ s3_ff));
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_ff <= PINS_IDLE;
            s2_ff <= PINS_IDLE;
            s3_ff <= PINS_IDLE;
            cln_ff <= PINS_IDLE;
            prv_ff <= PINS_IDLE;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            cln_ff <= nxt_cln;
            prv_ff <= cln_ff;
        end
    end

    assign active = !cln_ff.cs_n && ctrl_en_ff;
    assign ser = active && cln_ff.mode == MODE_SER;
    assign sep = active && cln_ff.mode == MODE_SEP;
    assign dsm = active && cln_ff.mode == MODE_DS;
    assign sclk_rise = cln_ff.shift_clk && !prv_ff.shift_clk;
    assign sclk_fall = !cln_ff.shift_clk && prv_ff.shift_clk;
    assign act_edge = ser && (cln_ff.output_edge_select ? sclk_fall : sclk_rise);
    assign rd_act = sep && !cln_ff.rd_n;
    assign wr_act = sep && !cln_ff.wr_n;
    assign wr_rise = sep && cln_ff.wr_n && !prv_ff.wr_n;
    assign ds_act = dsm && !cln_ff.data_strobe_n;
    assign ds_wr = ds_act && prv_ff.data_strobe_n && !cln_ff.read_write;
    assign strb = rd_act || wr_act || ds_act;
    assign rdat = mem_ff[idx(addr_ff)];

    // serial framing: 8 command bits (read flag first), then 8 data bits
    always_ff @(posedge sys_clk) begin
        if (rst || !ser) begin
            cnt_ff <= 4'h0;
            sh_ff <= 8'h00;
            ser_rd_ff <= 1'b0;
        end else if (sclk_rise) begin
            sh_ff <= {sh_ff[6:0], cln_ff.serial_in_pin};
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == SER_CMD_LAST) begin
                ser_rd_ff <= sh_ff[6];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !ser) begin
            osh_ff <= 8'h00;
            sout_ff <= 1'b0;
        end else if (sclk_rise && cnt_ff == SER_CMD_LAST) begin
            osh_ff <= mem_ff[idx({sh_ff[6:0], cln_ff.serial_in_pin})];
        end else if (act_edge && cnt_ff > SER_CMD_LAST && ser_rd_ff) begin
            sout_ff <= osh_ff[7];
            osh_ff <= {osh_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_ff <= 8'h00;
        end else if (ser && sclk_rise && cnt_ff == SER_CMD_LAST) begin
            addr_ff <= {1'b0, sh_ff[5:0], cln_ff.serial_in_pin};
        end else if ((sep && cln_ff.addr_latch != prv_ff.addr_latch && !cln_ff.addr_latch) ||
                     (dsm && !cln_ff.addr_strobe_input && prv_ff.addr_strobe_input)) begin
            addr_ff <= cln_ff.ad;
        end
    end

    // parallel access timer; a released strobe ends the access at once
    always_ff @(posedge sys_clk) begin
        if (rst || !strb) begin
            acc_ff <= ACC_IDLE;
            wcnt_ff <= 8'h00;
        end else begin
            case (acc_ff)
                ACC_IDLE: begin
                    acc_ff <= ACC_WAIT;
                    wcnt_ff <= 8'h00;
                end
                ACC_WAIT: begin
                    if (wcnt_ff >= 8'(ACC_CYC - 1)) begin
                        acc_ff <= ACC_DONE;
                    end else begin
                        wcnt_ff <= wcnt_ff + 8'h01;
                    end
                end
                ACC_DONE: acc_ff <= ACC_DONE;
                default: acc_ff <= ACC_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ready_ff <= 1'b1;
            ack_ff <= 1'b1;
            ad_oe_ff <= 1'b0;
            ad_out_ff <= 8'h00;
        end else begin
            ready_ff <= !(rd_act || wr_act) || acc_ff == ACC_DONE;
            ack_ff <= !(ds_act && acc_ff == ACC_DONE);
            ad_oe_ff <= rd_act || (ds_act && cln_ff.read_write);
            ad_out_ff <= rdat;
        end
    end

    // the write strobe and the data pass the same synchroniser, so the data seen
    // one cycle before the strobe rise is used: the host may move it right after
    always_comb begin
        wr_en = 1'b0;
        wr_idx = idx(addr_ff);
        wr_dat = cln_ff.ad;
        if (ser && sclk_rise && cnt_ff == SER_DATA_LAST && !ser_rd_ff) begin
            wr_en = 1'b1;
            wr_dat = {sh_ff[6:0], cln_ff.serial_in_pin};
        end else if (wr_rise) begin
            wr_en = 1'b1;
            wr_dat = prv_ff.ad;
        end else if (ds_wr) begin
            wr_en = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_ff[wr_idx] <= wr_dat;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_wd_ff <= 8'h00;
            wr_cnt_ff <= 16'h0000;
        end else if (wr_en) begin
            last_wd_ff <= wr_dat;
            wr_cnt_ff <= wr_cnt_ff + 16'h0001;
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rd_word[CTRL_EN_BIT] = ctrl_en_ff;
            OFS_STAT: begin
                rd_word[STAT_MODE_LSB +: 2] = cln_ff.mode;
                rd_word[STAT_CS_BIT] = !cln_ff.cs_n;
                rd_word[STAT_BUSY_BIT] = strb;
            end
            OFS_LAST: begin
                rd_word[7:0] = addr_ff;
                rd_word[LAST_WD_LSB +: 8] = last_wd_ff;
            end
            OFS_CNT: rd_word[15:0] = wr_cnt_ff;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // zero wait states: data and error are prepared in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= psel && !penable;
            if (psel && !penable) begin
                prdata_ff <= rd_word;
                pslverr_ff <= !(paddr == OFS_CTRL || paddr == OFS_STAT ||
                                paddr == OFS_LAST || paddr == OFS_CNT);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_en_ff <= CTRL_EN_RST;
        end else if (psel && penable && pready_ff && pwrite && paddr == OFS_CTRL) begin
            ctrl_en_ff <= pwdata[CTRL_EN_BIT];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign ad_out = ad_out_ff;
    assign ad_oe = ad_oe_ff;
    assign serial_out_pin = sout_ff;
    assign ack_n = ack_ff;
    assign ready_out = ready_ff;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_ds_wr;
        ds_wr;
    endsequence

    sequence s_sep_start;
        $rose(rd_act || wr_act);
    endsequence

    a_sout_edge: assert property ($changed(sout_ff) |-> $past(act_edge) || !$past(ser))
        else $error("serial out moved off its active edge");
    a_ack_read: assert property (!ack_ff && cln_ff.read_write && ds_act |-> ad_oe_ff)
        else $error("acknowledge without read data on bus");
    a_ack_write: assert property (s_ds_wr |-> ##[1:8] (!ack_ff || cln_ff.data_strobe_n))
        else $error("write not acknowledged");
    a_rdy_busy: assert property (s_sep_start |=> !ready_ff ##[1:8] ready_ff)
        else $error("ready did not show access in progress then done");
    a_rd_drive: assert property (rd_act [*2] |-> ad_oe_ff && ad_out_ff == $past(rdat))
        else $error("read data not driven during read strobe");
    a_ds_write: assert property (s_ds_wr |=> mem_ff[idx(addr_ff)] == $past(cln_ff.ad))
        else $error("strobed write data not stored");
    a_ds_read: assert property ((ds_act && cln_ff.read_write) [*2] |-> ad_oe_ff)
        else $error("bus not driven on strobed read");
    a_bus_turn: assert property (ad_oe_ff |-> $past(rd_act) || ($past(ds_act) && $past(cln_ff.read_write)))
        else $error("bus driven outside a read data phase");
    a_cs_quiet: assert property (!active |=> !ad_oe_ff && ack_ff && ready_ff)
        else $error("host interface answered while deselected");
    a_sin_shift: assert property (ser && sclk_rise |=> sh_ff[0] == $past(cln_ff.serial_in_pin))
        else $error("serial input not sampled on rise");
    a_addr_latch: assert property (sep && $fell(cln_ff.addr_latch) |=> addr_ff == $past(cln_ff.ad))
        else $error("address not latched on latch fall");
    a_mode_sel: assert property (ad_oe_ff |->
        $past(cln_ff.mode) == MODE_SEP || $past(cln_ff.mode) == MODE_DS)
        else $error("bus driven outside parallel modes");
    a_wr_commit: assert property (wr_rise |=> mem_ff[idx(addr_ff)] == $past(prv_ff.ad))
        else $error("write data not stored on strobe rise");
    a_rd_release: assert property ($fell(rd_act) |=> !ad_oe_ff)
        else $error("bus still driven after read strobe release");
    a_ack_release: assert property ($fell(ds_act) |=> ack_ff)
        else $error("acknowledge held after data strobe release");
endmodule

//--- sim/hcp_host_model.sv
`timescale 1ns/1ns
module hcp_host_model import hcp_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic [7:0] ad_out, // device bus out
    input wire logic ad_oe, // device drives bus
    input wire logic serial_out_pin, // serial out
    input wire logic ack_n, // ds acknowledge
    input wire logic ready_out, // sep ready
    output hcp_pins_t p, // host pins
    output logic h_oe // host drives bus
);
    initial p = PINS_IDLE;
    initial h_oe = 1'b0;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic setup(input logic [1:0] m, input logic es);
        p.mode <= m;
        p.output_edge_select <= es;
        cyc(8);
    endtask
    // sampling lands just before the next active edge, as the pin sync delay exceeds half a period
    task automatic ser(input logic sel_n, input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        p.cs_n <= sel_n;
        p.serial_in_pin <= sh[15];
        for (int i = 0; i <= 16; i++) begin
            cyc(4);
            if (!p.output_edge_select && i >= 9) rd = {rd[6:0], serial_out_pin};
            if (i == 16) break;
            p.shift_clk <= 1'b1;
            cyc(4);
            if (p.output_edge_select && i >= 8) rd = {rd[6:0], serial_out_pin};
            p.shift_clk <= 1'b0;
            sh = sh << 1;
            p.serial_in_pin <= sh[15];
        end
        p.cs_n <= 1'b1;
        cyc(4);
    endtask
    task automatic par(input logic ds, input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [10:0] r);
        logic low;
        p.cs_n <= 1'b0;
        p.ad <= a;
        h_oe <= 1'b1;
        if (ds) p.addr_strobe_input <= 1'b1;
        else p.addr_latch <= 1'b1;
        cyc(6);
        p.addr_strobe_input <= 1'b0;
        p.addr_latch <= 1'b0;
        cyc(6);
        p.ad <= d;
        h_oe <= wr;
        p.read_write <= !wr;
        cyc(1);
        if (ds) p.data_strobe_n <= 1'b0;
        else if (wr) p.wr_n <= 1'b0;
        else p.rd_n <= 1'b0;
        low = 1'b0;
        for (int i = 0; i < 40; i++) begin
            if (ds ? !ack_n : low && ready_out) break;
            low = low | !ready_out;
            cyc(1);
        end
        r[10] = ds ? !ack_n : low && ready_out;
        cyc(2);
        r[9] = ad_oe;
        r[7:0] = ad_out;
        p.data_strobe_n <= 1'b1;
        p.wr_n <= 1'b1;
        p.rd_n <= 1'b1;
        cyc(8);
        r[8] = ad_oe | !ack_n | !ready_out;
        h_oe <= 1'b0;
        p.cs_n <= 1'b1;
        cyc(2);
    endtask
endmodule

//--- sim/hcp_host_port_tb.sv
`timescale 1ns/1ns
module hcp_host_port_tb import hcp_pkg::*; ;
    logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, h_oe, ad_oe, sop, ack_n, ready_out, e;
    logic [7:0] paddr, ad_out, ad_fill, bus, a, wd, rd;
    logic [31:0] pwdata, prdata, r;
    logic [10:0] pr;
    hcp_pins_t p;
    int failures, samples_checked, seed;
    string nm_q[$];
    logic [31:0] ex_q[$], sn_q[$];
    // undriven bus shows a moving pattern so a stale value never matches
    assign bus = ad_oe ? ad_out : h_oe ? p.ad : ad_fill;
    hcp_host_port dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_sel_n(p.cs_n), .if_mode(p.mode), .shift_clk(p.shift_clk), .serial_in_pin(p.serial_in_pin),
        .output_edge_select(p.output_edge_select), .addr_latch(p.addr_latch),
        .addr_strobe_input(p.addr_strobe_input), .rd_n(p.rd_n), .wr_n(p.wr_n),
        .data_strobe_n(p.data_strobe_n), .read_write(p.read_write), .ad_in(bus), .ad_out(ad_out),
        .ad_oe(ad_oe), .serial_out_pin(sop), .ack_n(ack_n), .ready_out(ready_out));
    hcp_host_model u_host (.sys_clk(sys_clk), .ad_out(ad_out), .ad_oe(ad_oe), .serial_out_pin(sop),
        .ack_n(ack_n), .ready_out(ready_out), .p(p), .h_oe(h_oe));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) ad_fill <= rst ? 8'h5A : ~ad_fill;
    task automatic close_out();
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] ex, input logic [31:0] sn);
        nm_q.push_back(s);
        ex_q.push_back(ex);
        sn_q.push_back(sn);
    endtask
    task automatic cmp_val(input string s, input logic [31:0] ex, input logic [31:0] sn);
        samples_checked++;
        if (sn !== ex) begin
            failures++;
            $display("ERROR %s expected %h seen %h", s, ex, sn);
        end
    endtask
    initial forever begin
        wait (sn_q.size() > 0);
        cmp_val(nm_q[0], ex_q[0], sn_q[0]);
        void'(nm_q.pop_front());
        void'(ex_q.pop_front());
        void'(sn_q.pop_front());
    end
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    initial begin
        #2_000_000;
        failures++;
        close_out();
    end
    initial begin
        seed = 90541;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk("ctrl", {31'h0, CTRL_EN_RST}, r);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {r[30:0], e});
        for (int m = 0; m < 4; m++) begin
            u_host.setup(m[1:0], 1'b0);
            apb(1'b0, OFS_STAT, 32'h0000_0000);
            chk("mode", 32'(m), r);
        end
        for (int k = 0; k < 2; k++) begin
            u_host.setup(k[0] ? MODE_DS : MODE_SEP, 1'b0);
            wd = 8'($random(seed));
            a = 8'($random(seed)) & 8'h0F;
            u_host.par(k[0], 1'b1, a, wd, pr);
            chk("par_wr", 32'h0000_0004, {29'h0, pr[10:8]});
            u_host.par(k[0], 1'b0, a, 8'h00, pr);
            chk("par_rd", {21'h0, 3'b110, wd}, {21'h0, pr});
            apb(1'b0, OFS_LAST, 32'h0000_0000);
            chk("last", {16'h0, wd, a}, {16'h0, r[15:0]});
        end
        for (int k = 0; k < 2; k++) begin
            u_host.setup(MODE_SER, k[0]);
            wd = 8'($random(seed));
            a = 8'($random(seed)) & 8'h0F;
            u_host.ser(1'b0, a, wd, rd);
            u_host.ser(1'b0, a | 8'h80, 8'h00, rd);
            chk("ser_rd", {24'h0, wd}, {24'h0, rd});
        end
        u_host.ser(1'b1, a, ~wd, rd);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        u_host.ser(1'b0, a, wd ^ 8'h0F, rd);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        u_host.ser(1'b0, a | 8'h80, 8'h00, rd);
        chk("ser_ignored", {24'h0, wd}, {24'h0, rd});
        apb(1'b0, OFS_CNT, 32'h0000_0000);
        chk("wr_count", 32'h0000_0004, r);
        wait (sn_q.size() == 0);
        close_out();
    end
endmodule
